// file: common/tsx_pkg.sv
package tsx_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CODE_BITS = 5;
  // impulse lengths in milliseconds
  localparam int unsigned UNIT_MS = 22;
  localparam int unsigned STOP_MS = 31;
  localparam int unsigned UNIT_CYC = UNIT_MS * (CLK_HZ / 1000);
  localparam int unsigned STOP_CYC = STOP_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 20;
  localparam logic [3:0] LINE_MARK = 4'h1;
  typedef enum logic [2:0] {
    TSX_IDLE  = 3'b000,
    TSX_START = 3'b001,
    TSX_CODE  = 3'b011,
    TSX_STOP  = 3'b010,
    TSX_FEED  = 3'b110
  } tsx_state_t;
endpackage

// file: verilog/tsx_transmitter.sv
`timescale 1ns/100ps
module tsx_transmitter #(
  parameter int unsigned UNIT_CYCLES = tsx_pkg::UNIT_CYC,
  parameter int unsigned STOP_CYCLES = tsx_pkg::STOP_CYC
) (
  input wire logic ref_clk_i,                           // 25 MHz clock
  input wire logic reset_n_i,                           // async reset, active low
  input wire logic run_i,                               // run control from switch chain
  input wire logic tape_present_i,                      // tape under the sensing pins
  input wire logic [tsx_pkg::CODE_BITS-1:0] holes_i,    // sensed holes, 1 = punched
  output logic line_mark_o,                             // 1 = contacts closed, current
  output logic sense_o,                                 // sensing pins raised
  output logic claw_engaged_o,                          // feed claw in the feed holes
  output logic feed_step_o,                             // one-cycle tape advance pulse
  output logic busy_o                                   // character cycle in progress
);
  tsx_pkg::tsx_state_t state_reg;
  logic [tsx_pkg::CNT_W-1:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [tsx_pkg::CODE_BITS-1:0] code_reg;
  logic run_ok;
  logic cnt_done;
  logic [tsx_pkg::CNT_W-1:0] unit_last;
  logic [tsx_pkg::CNT_W-1:0] stop_last;

  assign unit_last = tsx_pkg::CNT_W'(UNIT_CYCLES - 1);
  assign stop_last = tsx_pkg::CNT_W'(STOP_CYCLES - 1);
  // tape out behaves as run dropped
  assign run_ok = run_i && tape_present_i;
  assign cnt_done = (state_reg == tsx_pkg::TSX_STOP) ? (cnt_reg == stop_last)
                                                      : (cnt_reg == unit_last);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= tsx_pkg::TSX_IDLE;
    end else begin
      case (state_reg)
        tsx_pkg::TSX_IDLE: begin
          if (run_ok) begin
            state_reg <= tsx_pkg::TSX_START;
          end
        end
        tsx_pkg::TSX_START: begin
          if (cnt_done) begin
            state_reg <= tsx_pkg::TSX_CODE;
          end
        end
        tsx_pkg::TSX_CODE: begin
          if (cnt_done && bit_reg == 3'(tsx_pkg::CODE_BITS - 1)) begin
            state_reg <= tsx_pkg::TSX_STOP;
          end
        end
        tsx_pkg::TSX_STOP: begin
          if (cnt_done) begin
            state_reg <= tsx_pkg::TSX_FEED;
          end
        end
        tsx_pkg::TSX_FEED: begin
          state_reg <= tsx_pkg::TSX_IDLE;
        end
        default: begin
          state_reg <= tsx_pkg::TSX_IDLE;
        end
      endcase
    end
  end

  // impulse timer, restarts at each impulse boundary
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
    end else if (state_reg == tsx_pkg::TSX_IDLE || state_reg == tsx_pkg::TSX_FEED
                 || cnt_done) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + tsx_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_reg <= '0;
    end else if (state_reg != tsx_pkg::TSX_CODE) begin
      bit_reg <= '0;
    end else if (cnt_done) begin
      bit_reg <= bit_reg + 3'(1);
    end
  end

  // latched once so a moving tape cannot corrupt a character
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_reg <= '0;
    end else if (state_reg == tsx_pkg::TSX_IDLE && run_ok) begin
      code_reg <= holes_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      line_mark_o <= 1'b1;
    end else begin
      case (state_reg)
        tsx_pkg::TSX_IDLE: line_mark_o <= !run_ok;
        tsx_pkg::TSX_START: begin
          if (cnt_done) begin
            line_mark_o <= code_reg[0];
          end
        end
        tsx_pkg::TSX_CODE: begin
          if (cnt_done) begin
            if (bit_reg == 3'(tsx_pkg::CODE_BITS - 1)) begin
              line_mark_o <= 1'b1;
            end else begin
              line_mark_o <= code_reg[bit_reg + 3'(1)];
            end
          end
        end
        default: line_mark_o <= 1'b1;
      endcase
    end
  end

  // claw drops at cycle start, rises during the last code impulse
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      claw_engaged_o <= 1'b1;
    end else if (state_reg == tsx_pkg::TSX_IDLE && run_ok) begin
      claw_engaged_o <= 1'b0;
    end else if (state_reg == tsx_pkg::TSX_CODE && bit_reg == 3'(tsx_pkg::CODE_BITS - 1)) begin
      claw_engaged_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      feed_step_o <= 1'b0;
    end else begin
      feed_step_o <= (state_reg == tsx_pkg::TSX_STOP) && cnt_done;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sense_o <= 1'b0;
    end else begin
      sense_o <= (state_reg == tsx_pkg::TSX_IDLE) && run_ok;
    end
  end

  assign busy_o = (state_reg != tsx_pkg::TSX_IDLE);

  // helper: cycles spent in the current impulse, cleared at each impulse boundary
  logic [tsx_pkg::CNT_W-1:0] hold_cnt;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_cnt <= '0;
    end else if (state_reg == tsx_pkg::TSX_IDLE) begin
      hold_cnt <= '0;
    end else begin
      hold_cnt <= cnt_done ? '0 : hold_cnt + tsx_pkg::CNT_W'(1);
    end
  end

  idle_mark_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_IDLE && $past(state_reg) == tsx_pkg::TSX_IDLE
    && !$past(run_ok) |-> line_mark_o)
    else $error("line not marking while idle");

  start_space_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_IDLE && run_ok |=> !line_mark_o && state_reg == tsx_pkg::TSX_START)
    else $error("start impulse not spacing");

  code_level_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_CODE |-> line_mark_o == code_reg[bit_reg])
    else $error("code impulse level wrong");

  stop_mark_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_STOP |-> line_mark_o)
    else $error("stop impulse not marking");

  unit_len_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg != tsx_pkg::TSX_STOP && state_reg != tsx_pkg::TSX_IDLE
    |-> hold_cnt <= unit_last)
    else $error("unit impulse too long");

  stop_len_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_STOP && $past(state_reg) == tsx_pkg::TSX_CODE
    |-> cnt_reg == '0)
    else $error("stop impulse timer not restarted");

  bit_order_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_CODE && cnt_done && bit_reg < 3'(tsx_pkg::CODE_BITS - 1)
    |=> bit_reg == $past(bit_reg) + 3'(1))
    else $error("code positions out of order");

  feed_after_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    feed_step_o |-> state_reg == tsx_pkg::TSX_FEED && $past(state_reg) == tsx_pkg::TSX_STOP)
    else $error("tape fed outside feed slot");

  claw_drop_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_START |-> !claw_engaged_o)
    else $error("claw engaged at group start");

  claw_up_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_STOP |-> claw_engaged_o)
    else $error("claw not re-engaged before stop");

  code_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg != tsx_pkg::TSX_IDLE |=> $stable(code_reg))
    else $error("code bits changed mid character");

  no_start_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_IDLE && !run_ok |=> state_reg == tsx_pkg::TSX_IDLE)
    else $error("cycle began without run");

  // a begun character must run out even if run drops mid way
  run_finish_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg != tsx_pkg::TSX_IDLE && state_reg != tsx_pkg::TSX_FEED && !run_ok
    |=> state_reg != tsx_pkg::TSX_IDLE)
    else $error("character cut short");

  busy_take_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_IDLE && run_ok |=> busy_o)
    else $error("busy not raised at take");

  tape_halt_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_IDLE && !tape_present_i |=> state_reg == tsx_pkg::TSX_IDLE)
    else $error("cycle began with tape out");

  first_bit_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_START && cnt_done
    |=> state_reg == tsx_pkg::TSX_CODE && bit_reg == '0 && line_mark_o == code_reg[0])
    else $error("first code impulse wrong");

  code_count_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_CODE |-> bit_reg <= 3'(tsx_pkg::CODE_BITS - 1))
    else $error("more than five code impulses");

  // level may only move at an impulse boundary
  unit_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (state_reg == tsx_pkg::TSX_START || state_reg == tsx_pkg::TSX_CODE) && !cnt_done
    |=> $stable(line_mark_o))
    else $error("line moved inside an impulse");

  stop_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_STOP && !cnt_done |=> state_reg == tsx_pkg::TSX_STOP)
    else $error("stop impulse ended early");

  feed_mark_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_FEED |-> line_mark_o)
    else $error("line not marking during feed");

  sense_slot_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    sense_o |-> state_reg == tsx_pkg::TSX_START && cnt_reg == '0)
    else $error("sense pulse outside cycle start");

  sense_claw_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    sense_o |-> !claw_engaged_o)
    else $error("claw engaged while sensing");

  feed_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    feed_step_o |=> !feed_step_o)
    else $error("feed step longer than one cycle");

  // feeding with the claw down would slip the tape
  feed_claw_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    feed_step_o |-> claw_engaged_o)
    else $error("tape fed with claw disengaged");

  feed_idle_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    feed_step_o |=> state_reg == tsx_pkg::TSX_IDLE && !busy_o)
    else $error("not ready after feed step");

  char_cv: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    feed_step_o);

  full_cv: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    feed_step_o && code_reg == 5'h1f);

  drop_cv: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_FEED && !run_i);

  back_cv: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_FEED ##2 state_reg == tsx_pkg::TSX_START);
  halt_cv: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_reg == tsx_pkg::TSX_CODE && !run_i);
endmodule // tsx_transmitter

// file: bench/tsx_line_model.sv
`timescale 1ns/100ps
module tsx_line_model #(
  parameter int unsigned UNIT_CYCLES = 8
) (
  input wire logic ref_clk_i, // bench clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic line_i,    // 1 = loop current flowing
  output logic [4:0] char_o,  // last character received
  output logic [7:0] count_o, // characters received
  output logic frame_err_o    // start or stop impulse wrong
);
  logic active_reg;
  logic [2:0] slot_reg;
  int unsigned sub_reg;
  // samples mid-impulse, as a real receiver would, so edges may wander a little
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_reg <= 1'h0;
      slot_reg <= 3'h0;
      sub_reg <= 0;
      char_o <= 5'h00;
      count_o <= 8'h00;
      frame_err_o <= 1'h0;
    end else if (!active_reg) begin
      active_reg <= !line_i;
      slot_reg <= 3'h0;
      sub_reg <= 1;
    end else begin
      sub_reg <= (sub_reg == UNIT_CYCLES - 1) ? 0 : sub_reg + 1;
      if (sub_reg == UNIT_CYCLES - 1) slot_reg <= slot_reg + 3'h1;
      if (sub_reg == UNIT_CYCLES / 2) begin
        if (slot_reg == 3'h0 && line_i) frame_err_o <= 1'h1;
        else if (slot_reg inside {[1:5]}) char_o[slot_reg - 3'h1] <= line_i;
        else if (slot_reg == 3'h6) begin
          active_reg <= 1'h0;
          count_o <= count_o + 8'h01;
          frame_err_o <= frame_err_o | !line_i;
        end
      end
    end
  end
endmodule // tsx_line_model

// file: bench/tsx_transmitter_test.sv
`timescale 1ns/100ps
module tsx_transmitter_test;
  localparam int unsigned U = 8;
  localparam int unsigned S = 11;
  localparam int unsigned LAST = 6 * U + S;
  logic ref_clk_i, reset_n_i, run_i, tape_present_i;
  logic [4:0] holes_i;
  logic line_mark_o, sense_o, claw_engaged_o, feed_step_o, busy_o;
  logic [4:0] rx_char;
  logic [7:0] rx_count;
  logic rx_err;
  int fails, checks_done, i;
  logic [4:0] pattern [0:5] = '{5'h00, 5'h1f, 5'h15, 5'h0a, 5'h01, 5'h10};
  tsx_transmitter #(.UNIT_CYCLES(U), .STOP_CYCLES(S)) DUT (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .run_i(run_i), .tape_present_i(tape_present_i), .holes_i(holes_i),
    .line_mark_o(line_mark_o), .sense_o(sense_o), .claw_engaged_o(claw_engaged_o),
    .feed_step_o(feed_step_o), .busy_o(busy_o));
  tsx_line_model #(.UNIT_CYCLES(U)) far_end (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .line_i(line_mark_o), .char_o(rx_char), .count_o(rx_count), .frame_err_o(rx_err));
  initial begin
    ref_clk_i = 1'h0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hold_off(input logic run, input logic tape);
    for (int k = 0; k < 20; k++) begin
      @(posedge ref_clk_i);
      run_i <= run;
      tape_present_i <= tape;
      #1;
      chk("busy held off", busy_o, 8'h00);
      chk("idle line", line_mark_o, 8'h01);
    end
    $display("test hold_off %b %b done", run, tape);
  endtask
  // holes change two edges after the take edge and the line must not notice
  task automatic send_char(input logic [4:0] h, input logic [4:0] nxt, input bit drop);
    logic exp_line;
    logic [7:0] rx_before;
    rx_before = rx_count;
    for (int k = 0; k < 8 && busy_o !== 1'h1; k++) begin
      @(posedge ref_clk_i);
      run_i <= 1'h1;
      #1;
    end
    if (busy_o !== 1'h1) begin
      fails++;
      end_of_test();
    end
    chk("sense pulse", sense_o, 8'h01);
    for (int k = 0; k <= LAST; k++) begin
      exp_line = (k < U) ? 1'h0 : (k < 6 * U) ? h[k / U - 1] : 1'h1;
      chk("line level", line_mark_o, 8'(exp_line));
      chk("feed step", feed_step_o, 8'(k == LAST));
      if (k == 0) chk("claw at start", claw_engaged_o, 8'h00);
      if (k == 6 * U) chk("claw before stop", claw_engaged_o, 8'h01);
      @(posedge ref_clk_i);
      if (k == 1) holes_i <= ~h;
      if (k == 2 && drop) run_i <= 1'h0;
      if (k == LAST - 1) holes_i <= nxt;
      #1;
    end
    chk("busy after feed", busy_o, 8'h00);
    chk("feed ends", feed_step_o, 8'h00);
    chk("received char", 8'(rx_char), 8'(h));
    chk("received count", rx_count, rx_before + 8'h01);
    chk("frame error", 8'(rx_err), 8'h00);
    $display("test send_char %h done", h);
  endtask
  initial begin
    reset_n_i = 1'h0;
    run_i = 1'h0;
    tape_present_i = 1'h1;
    holes_i = 5'h00;
    fails = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'h1;
    @(posedge ref_clk_i);
    #1;
    chk("reset line", line_mark_o, 8'h01);
    chk("reset claw", claw_engaged_o, 8'h01);
    chk("reset busy", busy_o, 8'h00);
    $display("test reset done");
    hold_off(1'h0, 1'h1);
    hold_off(1'h1, 1'h0);
    hold_off(1'h0, 1'h1);
    for (i = 0; i < 6; i++) send_char(pattern[i], pattern[(i + 1) % 6], i == 5);
    hold_off(1'h0, 1'h1);
    end_of_test();
  end
endmodule // tsx_transmitter_test
